// ### logic/ebt_pkg.sv
// constants shared by the interval timer block
package ebt_pkg;
  // register indices and byte addresses (address = index * 4)
  localparam logic [7:0] EBT_MODE_IDX = 8'hD8;
  localparam logic [7:0] EBT_COUNT_IDX = 8'hD9;
  localparam logic [7:0] EBT_STAT_IDX = 8'hE0;
  localparam logic [7:0] EBT_IEN_IDX = 8'hE1;
  localparam logic [11:0] EBT_MODE_ADDR = {2'b00, EBT_MODE_IDX, 2'b00};
  localparam logic [11:0] EBT_COUNT_ADDR = {2'b00, EBT_COUNT_IDX, 2'b00};
  localparam logic [11:0] EBT_STAT_ADDR = {2'b00, EBT_STAT_IDX, 2'b00};
  localparam logic [11:0] EBT_IEN_ADDR = {2'b00, EBT_IEN_IDX, 2'b00};
  // mode register field positions
  localparam int EBT_ENB_BIT = 7;
  localparam int EBT_RATE_HI = 6;
  localparam int EBT_RATE_LO = 4;
  localparam int EBT_SRC_BIT = 0;
  // values after reset, and the top count
  localparam logic [7:0] EBT_MODE_RST = 8'h00;
  localparam logic [7:0] EBT_COUNT_RST = 8'h00;
  localparam logic [7:0] EBT_MAX_COUNT = 8'hFF;
  // real-time source and its fixed interval
  localparam int EBT_RTC_FREQ_HZ = 32768;
  localparam int EBT_RTC_INTERVAL_MS = 500;
  localparam int EBT_COUNT_SPAN = 256;
  localparam int EBT_RTC_DIV = EBT_RTC_FREQ_HZ * EBT_RTC_INTERVAL_MS / 1000 / EBT_COUNT_SPAN;
  localparam logic [2:0] EBT_RTC_CODE = 3'(8 - $clog2(EBT_RTC_DIV));
  // bus answers
  localparam logic [1:0] EBT_RESP_OKAY = 2'b00;
  localparam logic [1:0] EBT_RESP_SLVERR = 2'b10;
endpackage

// ### logic/ebt_tick_if.sv
// link between the timer core and one prescaler
`timescale 1ns/1ns
interface ebt_tick_if;
  logic run;
  logic step;
  logic [2:0] sel;
  logic tick;
  modport prescaler (input run, input step, input sel, output tick);
  modport user (output run, output step, output sel, input tick);
endinterface

// ### logic/ebt_prescaler.sv
// power-of-two prescaler giving a one-cycle tick
`timescale 1ns/1ns
module ebt_prescaler
  import ebt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control and tick
  ebt_tick_if.prescaler tk
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } ebt_pre_state_type;

  ebt_pre_state_type st_reg, st_next;
  logic [7:0] low_mask; // bits that must all be one

  // divide by 2^(8-sel): count step pulses
  always_comb begin
    st_next = st_reg;
    low_mask = 8'hFF >> tk.sel;
    st_next.tick = 1'b0;
    if (!tk.run) begin
      st_next.cnt = 8'h00;
    end else if (tk.step) begin
      // R7: tick on each 2^(8-sel) steps
      st_next.tick = ((st_reg.cnt & low_mask) == low_mask);
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick = st_reg.tick;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_div_tick: assert property (tk.tick |-> $past(tk.run) && $past(tk.step) // R7
    && (($past(st_reg.cnt) & $past(low_mask)) == $past(low_mask)))
    else $error("prescaler tick off its boundary");
endmodule

// ### logic/ebt_timer.sv
// eight-bit interval timer with real-time mode and register slave
// ------------------------------------------------------------
// Overview of operation
// R1: up counter, roll-over raises time-out request
// R2: real-time mode needs the rc-with-rtc option
// R3: enabled timer time-out wakes from green mode
// R4: software clears request after half rtc period
// R5: real-time mode spans 256 counts, half second
// R6: mode bit 7 runs or stops, reset clears
// R7: mode bits 6:4 divide clock by 2^(8-code)
// R8: mode bit 0 selects real-time source
// R9: rate field ignored in real-time mode
// R10: count register loads on write, reads live
// R11: software does not write count in real-time
// R12: software preloads 256 minus interval times rate
// R13: software follows the stop-configure-enable order
// R14: sticky request, gated by interrupt enable
// ------------------------------------------------------------
`timescale 1ns/1ns
module ebt_timer
  import ebt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // real-time source and option strap
  input wire logic rtc_clk_in,
  input wire logic internal_rc_with_rtc_option,
  // interrupt and wake-up
  output logic irq,
  output logic green_wake
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic count_enable_bit;     // mode bit 7
    logic [2:0] prescale_select; // mode bits 6:4
    logic rtc_source_select;    // mode bit 0
    logic [7:0] count;          // live counter
    logic overflow_request_flag; // sticky status
    logic overflow_irq_enable;  // interrupt mask
    logic rtc_prev;             // last rtc level
    logic irq;                  // interrupt output
    logic wake;                 // wake-up pulse
    logic [11:0] awaddr;        // held write address
    logic aw_got;               // write address taken
    logic [7:0] wdata;          // held write byte
    logic wbyte;                // low lane strobed
    logic w_got;                // write data taken
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ebt_state_type;

  ebt_state_type st_reg, st_next;

  // prescaler links
  ebt_tick_if cpu_tk ();
  ebt_tick_if rtc_tk ();

  // ------------------------------------------------------------
  // prescalers
  // ------------------------------------------------------------
  // cpu clock prescaler, rate from mode register
  ebt_prescaler u_cpu_pre (
    .clk(clk),
    .srst(srst),
    .tk(cpu_tk)
  );

  // real-time prescaler, fixed half-second span
  ebt_prescaler u_rtc_pre (
    .clk(clk),
    .srst(srst),
    .tk(rtc_tk)
  );

  logic rtc_mode;     // real-time counting in force
  logic count_tick;   // one count step this cycle
  logic do_write;     // write commits this cycle
  logic wr_count;     // write hits count register
  logic roll;         // counter rolls over
  logic [7:0] rd_byte; // read value before widening
  logic rd_ok;        // read address is mapped

  // R2: real-time mode only with the rc-with-rtc option
  assign rtc_mode = st_reg.rtc_source_select && internal_rc_with_rtc_option;

  // R8: source choice drives which prescaler runs
  assign cpu_tk.run = st_reg.count_enable_bit && !rtc_mode;
  assign cpu_tk.step = 1'b1;
  assign cpu_tk.sel = st_reg.prescale_select;
  // R9: rate field does not reach the real-time path
  assign rtc_tk.run = st_reg.count_enable_bit && rtc_mode;
  assign rtc_tk.step = rtc_clk_in && !st_reg.rtc_prev;
  // R5: fixed divider gives 256 counts per half second
  assign rtc_tk.sel = EBT_RTC_CODE;

  assign count_tick = rtc_mode ? rtc_tk.tick : cpu_tk.tick;
  assign do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign wr_count = do_write && st_reg.wbyte && (st_reg.awaddr == EBT_COUNT_ADDR);
  assign roll = count_tick && st_reg.count_enable_bit && (st_reg.count == EBT_MAX_COUNT);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // select the byte for a read address
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      EBT_MODE_ADDR: begin
        rd_byte = {st_reg.count_enable_bit, st_reg.prescale_select, 3'b000,
                   st_reg.rtc_source_select};
      end
      EBT_COUNT_ADDR: begin
        rd_byte = st_reg.count;
      end
      EBT_STAT_ADDR: begin
        rd_byte = {7'b000_0000, st_reg.overflow_request_flag};
      end
      EBT_IEN_ADDR: begin
        rd_byte = {7'b000_0000, st_reg.overflow_irq_enable};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rtc_prev = rtc_clk_in;
    st_next.wake = 1'b0;

    // write address channel
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.awaddr = s_axi_awaddr;
      st_next.aw_got = 1'b1;
    end
    // write data channel
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.wdata = s_axi_wdata[7:0];
      st_next.wbyte = s_axi_wstrb[0];
      st_next.w_got = 1'b1;
    end

    // counting step
    if (count_tick && st_reg.count_enable_bit) begin
      // R1: roll from all ones to zero and keep going
      st_next.count = st_reg.count + 8'h01;
    end
    // R3: time-out while enabled wakes green mode
    if (roll) begin
      st_next.wake = 1'b1;
    end

    // commit of a write with both halves held
    if (do_write) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = EBT_RESP_OKAY;
      unique case (st_reg.awaddr)
        EBT_MODE_ADDR: begin
          if (st_reg.wbyte) begin
            // R6: bit 7 runs or stops the timer
            st_next.count_enable_bit = st_reg.wdata[EBT_ENB_BIT];
            // R7: rate code in bits 6:4
            st_next.prescale_select = st_reg.wdata[EBT_RATE_HI:EBT_RATE_LO];
            // R2: source bit holds only with the option
            st_next.rtc_source_select =
              st_reg.wdata[EBT_SRC_BIT] && internal_rc_with_rtc_option;
          end
        end
        EBT_COUNT_ADDR: begin
          // R10: write loads the present count
          if (st_reg.wbyte) begin
            st_next.count = st_reg.wdata;
          end
        end
        EBT_STAT_ADDR: begin
          // write one clears the request flag
          if (st_reg.wbyte && st_reg.wdata[0]) begin
            st_next.overflow_request_flag = 1'b0;
          end
        end
        EBT_IEN_ADDR: begin
          if (st_reg.wbyte) begin
            st_next.overflow_irq_enable = st_reg.wdata[0];
          end
        end
        default: begin
          st_next.bresp = EBT_RESP_SLVERR;
        end
      endcase
    end
    // R14: roll-over sets the sticky flag, set beats clear
    if (roll) begin
      st_next.overflow_request_flag = 1'b1;
    end
    // R14: interrupt passes only while enabled
    st_next.irq = st_next.overflow_request_flag && st_next.overflow_irq_enable;

    // write response channel
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;

    // read channels, one read under way at most
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = {24'h00_0000, rd_byte};
      st_next.rresp = rd_ok ? EBT_RESP_OKAY : EBT_RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid && !(s_axi_arvalid && st_reg.arready);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.count_enable_bit <= EBT_MODE_RST[EBT_ENB_BIT];
      st_reg.count <= EBT_COUNT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign irq = st_reg.irq;
  assign green_wake = st_reg.wake;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_roll_flag_set: assert property (roll && !wr_count // R1
    |=> st_reg.count == 8'h00 && st_reg.overflow_request_flag)
    else $error("roll-over did not wrap or flag");

  a_rtc_option_gate: assert property (!internal_rc_with_rtc_option // R2
    |-> !rtc_tk.run ##1 !rtc_tk.tick)
    else $error("real-time path ran without option");

  a_wake_on_roll: assert property (roll |=> green_wake ##1 !green_wake) // R3
    else $error("wake pulse missing or too long");

  a_rtc_step_only: assert property (rtc_mode && !rtc_tk.tick && !wr_count // R5
    |=> $stable(st_reg.count))
    else $error("real-time count moved without rtc tick");

  a_stopped_hold: assert property (!st_reg.count_enable_bit && !wr_count // R6
    |=> $stable(st_reg.count))
    else $error("stopped timer changed count");

  a_cpu_source: assert property (!rtc_mode && !cpu_tk.tick && !wr_count // R8
    |=> $stable(st_reg.count))
    else $error("cpu-source count moved without tick");

  a_rtc_rate_free: assert property (rtc_mode |-> !cpu_tk.run) // R9
    else $error("cpu prescaler ran in real-time mode");

  a_count_load: assert property (wr_count |=> st_reg.count == $past(st_reg.wdata)) // R10
    else $error("count write not loaded");

  a_irq_gate: assert property (irq == (st_reg.overflow_request_flag // R14
    && st_reg.overflow_irq_enable))
    else $error("interrupt does not follow flag and enable");

  a_flag_sticky: assert property (st_reg.overflow_request_flag // R14
    && !(do_write && st_reg.wbyte && st_reg.wdata[0] && st_reg.awaddr == EBT_STAT_ADDR)
    |=> st_reg.overflow_request_flag)
    else $error("request flag dropped without a clear");

  // reset values seen at the edge that ends the reset
  a_reset_clear: assert property (disable iff (1'b0) $past(srst) && !srst // R6
    |-> !st_reg.count_enable_bit && st_reg.count == EBT_COUNT_RST
    && !st_reg.overflow_request_flag && !irq)
    else $error("reset left the timer running or loaded");

  // one transfer at a time on each bus
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // R10
    else $error("write taken while response pending");

  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) // R10
    else $error("read taken while data pending");

  c_cpu_roll: cover property (roll && !rtc_mode);
  c_rtc_roll: cover property (roll && rtc_mode);
  c_irq_raised: cover property (!irq ##1 irq);
  c_write_read: cover property (s_axi_bvalid ##[1:8] s_axi_rvalid);
endmodule

// ### testbench/ebt_timer_bench.sv
// self-checking bench for the eight-bit interval timer
`timescale 1ns/1ns
module ebt_timer_bench
  import ebt_pkg::*;
;
  // ----------------------------------------
  // signals and table
  // ----------------------------------------
  logic clk, srst, rtc_clk_in, internal_rc_with_rtc_option, irq, green_wake;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] lane_mask; // write strobes offered
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] rtc_div; // slow source divider
  int n_errors, num_checks, cyc, rtc_edges, e0;
  // one row: address, value written, value read back, response
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [1:0] resp;
  } ebt_row_type;
  ebt_row_type rows [6];
  logic [11:0] regs [4];

  ebt_timer dut_u (.clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rtc_clk_in(rtc_clk_in),
    .internal_rc_with_rtc_option(internal_rc_with_rtc_option), .irq(irq),
    .green_wake(green_wake));

  // ----------------------------------------
  // clocks
  // ----------------------------------------
  always #4 clk = ~clk;
  // slow source, one rising edge per 16 cycles, edges counted here
  always @(posedge clk) begin
    rtc_div <= rtc_div + 3'h1;
    if (rtc_div == 3'h7) begin
      rtc_clk_in <= ~rtc_clk_in;
      if (!rtc_clk_in) rtc_edges <= rtc_edges + 1;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // verdict and end of run
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  // hold reset for 12 cycles
  task automatic do_reset();
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask
  // write: handshakes judged at the falling edge, released after the rising one
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic haw, hw, b;
    int n;
    b = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= 32'(d);
    s_axi_wstrb <= lane_mask;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 200) begin
      @(negedge clk);
      haw = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      n++;
      if (haw) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    // spare edge so a following call never re-raises bready in this step
    @(posedge clk);
    if (!b) begin
      n_errors++;
      results();
    end
  endtask
  // read: same discipline as the write
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic har, got;
    int n;
    got = 1'b0;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 200) begin
      @(negedge clk);
      har = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      n++;
      if (har) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    // spare edge so a following call never re-raises rready in this step
    @(posedge clk);
    if (!got) begin
      n_errors++;
      results();
    end
  endtask
  // cycles until the wake pulse, bounded
  task automatic wait_wake(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (green_wake !== 1'b1 && c < 5000);
    if (c >= 5000) begin
      n_errors++;
      results();
    end
    @(posedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    rtc_clk_in = 1'b0;
    rtc_div = 3'h0;
    rtc_edges = 0;
    internal_rc_with_rtc_option = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    lane_mask = 4'hF;
    n_errors = 0;
    num_checks = 0;
    rows = '{'{EBT_COUNT_ADDR, 8'hA5, 8'hA5, EBT_RESP_OKAY},
             '{EBT_MODE_ADDR, 8'h7E, 8'h70, EBT_RESP_OKAY},
             '{EBT_MODE_ADDR, 8'h01, 8'h00, EBT_RESP_OKAY},
             '{EBT_IEN_ADDR, 8'hFF, 8'h01, EBT_RESP_OKAY},
             '{EBT_STAT_ADDR, 8'h01, 8'h00, EBT_RESP_OKAY},
             '{12'h040, 8'h55, 8'h00, EBT_RESP_SLVERR}};
    regs = '{EBT_MODE_ADDR, EBT_COUNT_ADDR, EBT_STAT_ADDR, EBT_IEN_ADDR};
    do_reset();
    // register table rows, mode bit 0 refused without the option
    for (int i = 0; i < 6; i++) begin
      axi_write(rows[i].addr, rows[i].wdata, rsp);
      chk_val(32'(rsp), 32'(rows[i].resp));
      axi_read(rows[i].addr, rd, rsp);
      chk_val(rd, 32'(rows[i].rexp));
      chk_val(32'(rsp), 32'(rows[i].resp));
    end
    // second reset in mid-run clears every register
    axi_write(EBT_MODE_ADDR, 8'h70, rsp);
    do_reset();
    for (int i = 0; i < 4; i++) begin
      axi_read(regs[i], rd, rsp);
      chk_val(rd, 32'h0000_0000);
    end
    // every rate code: four counts from FC to the roll-over
    for (int c = 0; c < 8; c++) begin
      axi_write(EBT_STAT_ADDR, 8'h01, rsp);
      axi_write(EBT_COUNT_ADDR, 8'hFC, rsp);
      axi_write(EBT_MODE_ADDR, {1'b1, 3'(c), 4'h0}, rsp);
      wait_wake(cyc);
      chk_bit(cyc >= 3 * (1 << (8 - c)) && cyc <= 4 * (1 << (8 - c)) + 8, 1'b1);
      axi_read(EBT_COUNT_ADDR, rd, rsp);
      chk_bit(rd < 32'd5, 1'b1);
      axi_read(EBT_STAT_ADDR, rd, rsp);
      chk_val(rd, 32'h0000_0001);
      chk_bit(irq, 1'b0);
      axi_write(EBT_MODE_ADDR, 8'h00, rsp);
    end
    // stopped counter holds a loaded value
    axi_write(EBT_COUNT_ADDR, 8'h3C, rsp);
    repeat (40) @(posedge clk);
    axi_read(EBT_COUNT_ADDR, rd, rsp);
    chk_val(rd, 32'h0000_003C);
    // lane 0 not strobed: count keeps its value, answer still okay
    lane_mask = 4'hE;
    axi_write(EBT_COUNT_ADDR, 8'h11, rsp);
    lane_mask = 4'hF;
    chk_val(32'(rsp), 32'(EBT_RESP_OKAY));
    axi_read(EBT_COUNT_ADDR, rd, rsp);
    chk_val(rd, 32'h0000_003C);
    // interrupt: enable raises it, writing zero keeps it, writing one clears it
    axi_write(EBT_IEN_ADDR, 8'h01, rsp);
    repeat (2) @(negedge clk);
    chk_bit(irq, 1'b1);
    @(posedge clk);
    axi_write(EBT_STAT_ADDR, 8'h00, rsp);
    axi_read(EBT_STAT_ADDR, rd, rsp);
    chk_val(rd, 32'h0000_0001);
    axi_write(EBT_STAT_ADDR, 8'h01, rsp);
    repeat (2) @(negedge clk);
    chk_bit(irq, 1'b0);
    @(posedge clk);
    // real-time mode: rate field set but ignored, 64 source edges per count
    internal_rc_with_rtc_option <= 1'b1;
    axi_write(EBT_COUNT_ADDR, 8'hFE, rsp);
    e0 = rtc_edges;
    axi_write(EBT_MODE_ADDR, 8'hF1, rsp);
    wait_wake(cyc);
    chk_bit((rtc_edges - e0) >= 126 && (rtc_edges - e0) <= 130, 1'b1);
    axi_read(EBT_MODE_ADDR, rd, rsp);
    chk_val(rd, 32'h0000_00F1);
    chk_bit(irq, 1'b1);
    // clear the request only after half a source period
    repeat (8) @(posedge clk);
    axi_write(EBT_STAT_ADDR, 8'h01, rsp);
    axi_read(EBT_STAT_ADDR, rd, rsp);
    chk_val(rd, 32'h0000_0000);
    results();
  end
endmodule
